// *** verilog/rxphy_map.svh ***
// Register offsets, field positions, reset values and masks of the Phy_condition_report/config bank.
// Assumes an APB slave with a 12-bit byte address and one 32-bit word per register.
`ifndef RXPHY_MAP_SVH
`define RXPHY_MAP_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define RXPHY_ADDR_W 12
`define RXPHY_STATUS_OFS 12'h208
`define RXPHY_CFG_OFS 12'h214

// ----------------------------------------
// Status word fields
// ----------------------------------------
`define RXPHY_BUF_LSB 24
`define RXPHY_ALIGN_LSB 20
`define RXPHY_VLOW_LSB 12
`define RXPHY_PRBS_LSB 8
`define RXPHY_LOCK_LSB 4
`define RXPHY_RSTDONE_LSB 0

// ----------------------------------------
// Configuration word fields
// ----------------------------------------
`define RXPHY_TEST_BIT 31
`define RXPHY_SCHED_LSB 14
`define RXPHY_CEIL_LSB 12
`define RXPHY_EQOPT_LSB 10
`define RXPHY_SWING_LSB 0
`define RXPHY_CFG_RESET 32'h0000_0000
`define RXPHY_CFG_WMASK 32'h80ff_fc03

// ----------------------------------------
// Iteration bookkeeping
// ----------------------------------------
`define RXPHY_SCHED_LAST 3'h4
`define RXPHY_ITER_MAX 3'h7

`endif

// *** verilog/rxphy_pkg.sv ***
// Types shared by the Phy_condition_report/config bank.
// Assumes nothing beyond a SystemVerilog compiler.
package rxphy_pkg;
    typedef enum logic [1:0] {
        RXPHY_EQ_RAMP,
        RXPHY_EQ_HOLD,
        RXPHY_EQ_NA,
        RXPHY_EQ_TABLE
    } rxphy_eq_e;

    typedef logic [1:0] rxphy_level_t;
endpackage : rxphy_pkg

// *** verilog/rxphy_sync.sv ***
// Three-stage synchroniser for transceiver status levels.
// Assumes inputs are slow levels from another clock domain.
module rxphy_sync #(
    parameter int W = 28
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] agree;
    logic [W-1:0] sync_d;

    // Only the second and third stages are compared
    assign agree = ~(s2_q ^ s3_q);
    assign sync_d = (agree & s3_q) | (~agree & sync_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            sync_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            sync_q <= sync_d;
        end
    end
endmodule : rxphy_sync

// *** verilog/rxphy_preemp.sv ***
// Pre-emphasis adjust request generator for channel equalization iterations.
// Assumes eq_start and eq_iter are one-cycle pulses from training logic on pclk.
`include "rxphy_map.svh"

module rxphy_preemp
    import rxphy_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic eq_start,
    input wire logic eq_iter,
    input wire rxphy_eq_e eq_option,
    input wire rxphy_level_t ceiling,
    input wire logic [9:0] schedule,
    output rxphy_level_t preemp_request_q
);
    logic [2:0] iter_q;
    logic [2:0] iter_d;
    logic [2:0] sched_idx;
    rxphy_level_t ramp_lvl;
    rxphy_level_t sched_lvl;
    rxphy_level_t req_d;

    // Iterations past the fifth reuse the last schedule entry
    assign sched_idx = (iter_q > `RXPHY_SCHED_LAST) ? `RXPHY_SCHED_LAST : iter_q;
    assign sched_lvl = schedule[{sched_idx, 1'b0} +: 2]; // R10
    assign ramp_lvl = ({1'b0, ceiling} < iter_q) ? ceiling : iter_q[1:0]; // R13
    assign iter_d = eq_start ? 3'h0 :
                    (eq_iter && iter_q != `RXPHY_ITER_MAX) ? iter_q + 3'h1 : iter_q;
    assign req_d = !eq_iter ? preemp_request_q :
                   (eq_option == RXPHY_EQ_RAMP) ? ramp_lvl :
                   (eq_option == RXPHY_EQ_HOLD) ? ceiling : // R11 R14
                   (eq_option == RXPHY_EQ_TABLE) ? sched_lvl : 2'h0; // R12 R14

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            iter_q <= 3'h0;
            preemp_request_q <= 2'h0;
        end else begin
            iter_q <= iter_d;
            preemp_request_q <= req_d;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_hold_ceiling: assert property (@(posedge pclk) disable iff (!presetn) // R14
        eq_iter && eq_option == RXPHY_EQ_HOLD |=> preemp_request_q == $past(ceiling))
        else $error("hold option did not request the ceiling");
    a_ramp_capped: assert property (@(posedge pclk) disable iff (!presetn) // R13
        eq_iter && eq_option == RXPHY_EQ_RAMP |=> preemp_request_q <= $past(ceiling))
        else $error("ramp request exceeded the ceiling");
    a_ramp_first: assert property (@(posedge pclk) disable iff (!presetn) // R13
        eq_start ##1 (eq_iter && eq_option == RXPHY_EQ_RAMP) |=> preemp_request_q == 2'h0)
        else $error("ramp did not start at level zero");
    a_table_first: assert property (@(posedge pclk) disable iff (!presetn) // R10
        eq_start ##1 (eq_iter && eq_option == RXPHY_EQ_TABLE)
        |=> preemp_request_q == $past(schedule[1:0]))
        else $error("first iteration did not use lowest schedule pair");
    c_table_use: cover property (@(posedge pclk) disable iff (!presetn)
        eq_iter && eq_option == RXPHY_EQ_TABLE);
endmodule : rxphy_preemp

// *** verilog/rxphy_bank.sv ***
// Phy_condition_report and training configuration registers behind an APB slave.
// Assumes status pins come from transceiver clock domains; training pulses are on pclk.
//
// What this block does
// R1: Status reports two-bit receive buffer state per lane, lane 3 highest.
// R2: Status carries one byte-alignment flag per lane, bits 23 down to 20.
// R3: Low-voltage flags in two-bit fields per lane pair, lanes 2-3 upper.
// R4: PRBS errors in two-bit fields per lane pair, lanes 2-3 upper.
// R5: Lock flags: receiver clock 7, fabric PLL 6, lanes 2-3 PLL 5, lanes 0-1 PLL 4.
// R6: Reset-done in two-bit fields, lanes 2-3 above lanes 0-1 at bottom.
// R7: Training fails until every active lane swing reaches the programmed floor; three active lanes are judged as two.
// R8: Software should leave the configuration word at its default.
// R9: Top configuration bit puts the PHY into test mode.
// R10: Schedule field holds five two-bit levels, iteration 1 lowest.
// R11: Two-bit pre-emphasis level is ceiling or held value for requests.
// R12: Two-bit option picks how pre-emphasis adjust requests are produced.
// R13: Option 00 raises request one level per iteration up to ceiling.
// R14: Option 01 holds the ceiling, 11 uses schedule, 10 not applicable.
// R15: Lowest two configuration bits hold the minimum swing level.
// R16: Status reads show live conditions, unlatched; writes to it are ignored.
`include "rxphy_map.svh"

module rxphy_bank
    import rxphy_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`RXPHY_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata_q,
    output logic pready_q,
    output logic pslverr_q,
    input wire logic [7:0] rx_buf_status,
    input wire logic [3:0] lane_byte_aligned,
    input wire logic [3:0] rx_volt_low,
    input wire logic [3:0] prbs_error,
    input wire logic rx_clk_locked,
    input wire logic fabric_pll_locked,
    input wire logic pll23_locked,
    input wire logic pll01_locked,
    input wire logic [3:0] reset_done,
    input wire logic [2:0] active_lanes,
    input wire logic [7:0] lane_drive_setting,
    input wire logic eq_start,
    input wire logic eq_iter,
    output logic training_fail_q,
    output logic phy_test_mode_q,
    output logic [1:0] preemp_request_q
);
    // ----------------------------------------
    // Status synchronisation
    // ----------------------------------------
    logic [27:0] stat_raw;
    logic [27:0] stat_q;
    logic [31:0] status_word;

    assign stat_raw = {rx_buf_status, lane_byte_aligned, rx_volt_low, prbs_error,
                       rx_clk_locked, fabric_pll_locked, pll23_locked, pll01_locked,
                       reset_done};

    rxphy_sync #(.W(28)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(stat_raw),
        .sync_q(stat_q)
    );

    // Bits 19:16 are reserved and read zero
    assign status_word = {stat_q[27:20], // R1
                          stat_q[19:16], // R2
                          4'h0,
                          stat_q[15:12], // R3
                          stat_q[11:8], // R4
                          stat_q[7:4], // R5
                          stat_q[3:0]}; // R6

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    logic [31:0] cfg_q;
    logic [31:0] cfg_d;
    logic setup;
    logic access;
    logic hit_status;
    logic hit_cfg;
    logic hit_any;
    logic cfg_wr;
    logic [31:0] rdata_d;

    assign setup = psel && !penable;
    assign access = psel && penable && pready_q;
    assign hit_status = (paddr == `RXPHY_STATUS_OFS);
    assign hit_cfg = (paddr == `RXPHY_CFG_OFS);
    assign hit_any = hit_status || hit_cfg;
    assign cfg_wr = access && pwrite && hit_cfg;
    // Status is sampled at setup so a read reflects the live condition
    assign rdata_d = (!setup || pwrite) ? 32'h0000_0000 :
                     hit_status ? status_word : // R16
                     hit_cfg ? cfg_q : 32'h0000_0000;
    // Only documented fields are writable; writes to status fall through
    assign cfg_d = cfg_wr ? (pwdata & `RXPHY_CFG_WMASK) : cfg_q; // R16

    // Zero-wait slave: pready only in the access cycle after a setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && !hit_any;
            prdata_q <= rdata_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= `RXPHY_CFG_RESET;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // ----------------------------------------
    // Configuration fields
    // ----------------------------------------
    rxphy_level_t swing_floor;
    rxphy_level_t ceiling;
    rxphy_eq_e eq_option;
    logic [9:0] schedule;

    assign swing_floor = cfg_q[`RXPHY_SWING_LSB +: 2]; // R15
    assign ceiling = cfg_q[`RXPHY_CEIL_LSB +: 2]; // R11
    assign eq_option = rxphy_eq_e'(cfg_q[`RXPHY_EQOPT_LSB +: 2]); // R12
    assign schedule = cfg_q[`RXPHY_SCHED_LSB +: 10]; // R10

    // ----------------------------------------
    // Swing floor check
    // ----------------------------------------
    logic [3:0] lane_on;
    logic [3:0] lane_low;
    logic swing_fail_d;

    // Lanes beyond the active count are not judged
    assign lane_on = (active_lanes >= 3'h4) ? 4'hf :
                     (active_lanes >= 3'h2) ? 4'h3 :
                     (active_lanes >= 3'h1) ? 4'h1 : 4'h0;
    assign lane_low[0] = lane_drive_setting[1:0] < swing_floor;
    assign lane_low[1] = lane_drive_setting[3:2] < swing_floor;
    assign lane_low[2] = lane_drive_setting[5:4] < swing_floor;
    assign lane_low[3] = lane_drive_setting[7:6] < swing_floor;
    assign swing_fail_d = |(lane_low & lane_on); // R7

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            training_fail_q <= 1'b0;
            phy_test_mode_q <= 1'b0;
        end else begin
            training_fail_q <= swing_fail_d;
            phy_test_mode_q <= cfg_q[`RXPHY_TEST_BIT]; // R9
        end
    end

    // ----------------------------------------
    // Pre-emphasis requests
    // ----------------------------------------
    rxphy_preemp u_preemp (
        .pclk(pclk),
        .presetn(presetn),
        .eq_start(eq_start),
        .eq_iter(eq_iter),
        .eq_option(eq_option),
        .ceiling(ceiling),
        .schedule(schedule),
        .preemp_request_q(preemp_request_q)
    );

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    logic rd_status;
    assign rd_status = setup && !pwrite && hit_status;

    a_buf_field: assert property (@(posedge pclk) disable iff (!presetn) // R1
        rd_status |=> prdata_q[31:24] == $past(stat_q[27:20]))
        else $error("buffer status field misplaced");
    a_align_field: assert property (@(posedge pclk) disable iff (!presetn) // R2
        rd_status |=> prdata_q[23:16] == {$past(stat_q[19:16]), 4'h0})
        else $error("alignment flags misplaced");
    a_volt_prbs: assert property (@(posedge pclk) disable iff (!presetn) // R3 R4
        rd_status |=> prdata_q[15:8] == $past(stat_q[15:8]))
        else $error("low voltage or PRBS fields misplaced");
    a_lock_reset: assert property (@(posedge pclk) disable iff (!presetn) // R5 R6
        rd_status |=> prdata_q[7:0] == $past(stat_q[7:0]))
        else $error("lock or reset done fields misplaced");
    a_status_ro: assert property (@(posedge pclk) disable iff (!presetn) // R16
        access && pwrite && hit_status |=> $stable(cfg_q))
        else $error("status write changed configuration");
    a_swing_gate: assert property (@(posedge pclk) disable iff (!presetn) // R7
        active_lanes == 3'h4 && lane_drive_setting[7:6] < swing_floor
        |=> training_fail_q)
        else $error("training not failed below swing floor");
    a_swing_pass: assert property (@(posedge pclk) disable iff (!presetn) // R7
        active_lanes == 3'h1 && lane_drive_setting[1:0] >= swing_floor |=> !training_fail_q)
        else $error("training failed with swing met");
    a_test_mode: assert property (@(posedge pclk) disable iff (!presetn) // R9
        cfg_wr ##1 1'b1 |=> phy_test_mode_q == $past(pwdata[31], 2))
        else $error("test mode does not follow top bit");
    a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready_q ##1 !pready_q)
        else $error("access phase not exactly one cycle");
    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !hit_any |=> pslverr_q && prdata_q == 32'h0000_0000)
        else $error("unmapped address not flagged");

    // ----------------------------------------
    // Bus shape
    // ----------------------------------------
    a_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !setup |=> !pready_q)
        else $error("ready raised without a setup");
    a_rdata_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !setup || pwrite |=> prdata_q == 32'h0000_0000)
        else $error("read data outside a read access");
    a_mapped_okay: assert property (@(posedge pclk) disable iff (!presetn)
        setup && hit_any |=> !pslverr_q)
        else $error("error on a mapped address");
    a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr_q |-> pready_q)
        else $error("error response without ready");
    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        rd_status |=> prdata_q[19:16] == 4'h0)
        else $error("reserved status bits not zero");

    // ----------------------------------------
    // Configuration word
    // ----------------------------------------
    a_cfg_written: assert property (@(posedge pclk) disable iff (!presetn) // R15
        cfg_wr |=> cfg_q == ($past(pwdata) & `RXPHY_CFG_WMASK))
        else $error("configuration write not masked");
    a_cfg_kept: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg_wr |=> $stable(cfg_q))
        else $error("configuration changed without a write");
    a_cfg_read: assert property (@(posedge pclk) disable iff (!presetn) // R10 R11 R12
        setup && !pwrite && hit_cfg |=> prdata_q == $past(cfg_q))
        else $error("configuration read back wrong");
    a_test_follow: assert property (@(posedge pclk) disable iff (!presetn) // R9
        1'b1 |=> phy_test_mode_q == $past(cfg_q[`RXPHY_TEST_BIT]))
        else $error("test mode lags the top bit");

    // ----------------------------------------
    // Swing floor per lane
    // ----------------------------------------
    a_lane0_floor: assert property (@(posedge pclk) disable iff (!presetn) // R7
        active_lanes != 3'h0 && lane_drive_setting[1:0] < swing_floor |=> training_fail_q)
        else $error("lane 0 below floor not failed");
    a_lane1_floor: assert property (@(posedge pclk) disable iff (!presetn) // R7
        active_lanes >= 3'h2 && lane_drive_setting[3:2] < swing_floor |=> training_fail_q)
        else $error("lane 1 below floor not failed");
    a_lane2_floor: assert property (@(posedge pclk) disable iff (!presetn) // R7
        active_lanes >= 3'h4 && lane_drive_setting[5:4] < swing_floor |=> training_fail_q)
        else $error("lane 2 below floor not failed");
    a_no_lanes: assert property (@(posedge pclk) disable iff (!presetn) // R7
        active_lanes == 3'h0 |=> !training_fail_q)
        else $error("training failed with no active lane");

    // ----------------------------------------
    // Synchroniser settling
    // ----------------------------------------
    // Checker aid only: counts edges on which the raw status held still
    logic [27:0] raw_prev_q;
    logic [2:0] calm_q;
    logic [2:0] calm_d;

    assign calm_d = (stat_raw != raw_prev_q) ? 3'h0 :
                    (calm_q == 3'h7) ? calm_q : calm_q + 3'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_prev_q <= 28'h0000000;
            calm_q <= 3'h0;
        end else begin
            raw_prev_q <= stat_raw;
            calm_q <= calm_d;
        end
    end

    a_sync_settle: assert property (@(posedge pclk) disable iff (!presetn) // R16
        calm_q >= 3'h3 |-> stat_q == raw_prev_q)
        else $error("status not settled after calm edges");

    c_status_read: cover property (@(posedge pclk) disable iff (!presetn)
        rd_status ##1 pready_q);
    c_cfg_write: cover property (@(posedge pclk) disable iff (!presetn) cfg_wr);
    c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
        setup && !hit_any);
    c_train_fail: cover property (@(posedge pclk) disable iff (!presetn)
        training_fail_q ##1 !training_fail_q);
endmodule : rxphy_bank

// *** sim/rxphy_tx_model.sv ***
// Transmitter model: lane drive settings and equalization iteration pulses.
// Assumes one pclk domain; go is a one-cycle request from the bench.
module rxphy_tx_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic slow,
    input wire logic [7:0] swing,
    output logic [7:0] lane_drive_setting,
    output logic eq_start,
    output logic eq_iter
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] left_q;
    logic [1:0] gap_q;

    assign lane_drive_setting = swing;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eq_start <= 1'b0;
            eq_iter <= 1'b0;
            left_q <= 3'h0;
            gap_q <= 2'h0;
        end else begin
            eq_start <= go;
            eq_iter <= 1'b0;
            if (go) begin
                left_q <= 3'h5;
                gap_q <= 2'h0;
            end else if (left_q != 3'h0) begin
                if (gap_q != 2'h0) begin
                    gap_q <= gap_q - 2'h1;
                end else begin
                    eq_iter <= 1'b1;
                    left_q <= left_q - 3'h1;
                    // Slow partner idles three cycles between iterations
                    gap_q <= slow ? 2'h3 : 2'h0;
                end
            end
        end
    end
endmodule : rxphy_tx_model

// *** sim/rxphy_bank_tb.sv ***
// Self-checking bench for the Phy_condition_report and training configuration bank.
// Assumes the design files and the transmitter model are compiled first.
`include "rxphy_map.svh"

module rxphy_bank_tb
    import rxphy_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [9:0] SCHED = 10'h327;
    localparam logic [27:0] PAT = 28'h1be47d2;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [27:0] st = 28'h0;
    logic [2:0] active_lanes = 3'h4;
    logic [7:0] swing = 8'h00;
    logic go = 1'b0;
    logic slow = 1'b0;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, eq_start, eq_iter, training_fail_q, phy_test_mode_q;
    logic [7:0] lane_drive_setting;
    logic [1:0] preemp_request_q;
    int n_mismatch = 0;
    int num_checks = 0;

    always #20 pclk = ~pclk;

    rxphy_bank u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata_q, .pready_q, .pslverr_q,
        .rx_buf_status(st[27:20]), .lane_byte_aligned(st[19:16]),
        .rx_volt_low(st[15:12]), .prbs_error(st[11:8]),
        .rx_clk_locked(st[7]), .fabric_pll_locked(st[6]),
        .pll23_locked(st[5]), .pll01_locked(st[4]), .reset_done(st[3:0]),
        .active_lanes, .lane_drive_setting, .eq_start, .eq_iter,
        .training_fail_q, .phy_test_mode_q, .preemp_request_q
    );

    rxphy_tx_model u_tx (
        .pclk, .presetn, .go, .slow, .swing, .lane_drive_setting, .eq_start, .eq_iter
    );

    // ----
    // Helpers
    // ----
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic stall();
        n_mismatch++;
        $display("MISMATCH at %0t: wait ran out", $time);
        give_verdict();
    endtask : stall

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready_q !== 1'b1 && k < 20);
        if (pready_q !== 1'b1) stall();
        r = prdata_q;
        e = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk(e, exp_err, "write response");
    endtask : wr

    function automatic logic exp_fail(input logic [2:0] act, input logic [7:0] drv,
                                      input int f);
        int n;
        // Three lanes is not a legal width; it counts as two
        n = (act >= 3'h4) ? 4 : (act >= 3'h2) ? 2 : int'(act);
        for (int i = 0; i < n; i++) begin
            if (int'(drv[2*i +: 2]) < f) return 1'b1;
        end
        return 1'b0;
    endfunction : exp_fail

    function automatic logic [1:0] exp_pe(input int o, input int c, input int i);
        case (o)
            0: return (i - 1 < c) ? 2'(i - 1) : 2'(c);
            1: return 2'(c);
            3: return SCHED[2*(i-1) +: 2];
            default: return 2'h0;
        endcase
    endfunction : exp_pe

    // ----
    // Scenarios
    // ----
    task automatic t_status();
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 2; i++) begin
            @(posedge pclk);
            st <= (i == 0) ? PAT : ~PAT;
            wr(`RXPHY_STATUS_OFS, 32'hffffffff, 1'b0);
            repeat (6) @(posedge pclk);
            apb(1'b0, `RXPHY_STATUS_OFS, 32'h0, r, e);
            chk(r[31:24], st[27:20], "buffer status");
            chk(r[23:20], st[19:16], "byte aligned");
            chk(r[19:16], 4'h0, "unused bits");
            chk(r[15:12], st[15:12], "low voltage");
            chk(r[11:8], st[11:8], "prbs error");
            chk(r[7:4], st[7:4], "lock flags");
            chk(r[3:0], st[3:0], "reset done");
        end
        $display("status test done");
    endtask : t_status

    task automatic t_config();
        logic [31:0] r;
        logic e;
        apb(1'b0, `RXPHY_CFG_OFS, 32'h0, r, e);
        chk(r, 32'h00000000, "config reset value");
        wr(`RXPHY_CFG_OFS, 32'hffffffff, 1'b0);
        apb(1'b0, `RXPHY_CFG_OFS, 32'h0, r, e);
        chk(r, `RXPHY_CFG_WMASK, "config writable bits");
        chk(phy_test_mode_q, 1'b1, "test mode on");
        wr(`RXPHY_CFG_OFS, 32'h7fffffff, 1'b0);
        apb(1'b0, `RXPHY_CFG_OFS, 32'h0, r, e);
        chk(phy_test_mode_q, 1'b0, "test mode off");
        wr(12'h20c, 32'hffffffff, 1'b1);
        apb(1'b0, 12'h210, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1, "unmapped read");
        wr(`RXPHY_CFG_OFS, `RXPHY_CFG_RESET, 1'b0);
        $display("config test done");
    endtask : t_config

    task automatic t_training();
        logic [7:0] drv [3] = '{8'he4, 8'h1b, 8'hff};
        logic [2:0] act [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
        for (int f = 0; f < 4; f++) begin
            wr(`RXPHY_CFG_OFS, 32'(f), 1'b0);
            foreach (drv[d]) begin
                foreach (act[a]) begin
                    @(posedge pclk);
                    swing <= drv[d];
                    active_lanes <= act[a];
                    repeat (3) @(posedge pclk);
                    chk(training_fail_q, exp_fail(act[a], drv[d], f), "fail flag");
                end
            end
        end
        $display("training test done");
    endtask : t_training

    task automatic t_preemp();
        int k;
        for (int c = 1; c < 4; c += 2) begin
            for (int o = 0; o < 4; o++) begin
                wr(`RXPHY_CFG_OFS, {8'h00, SCHED, 2'(c), 2'(o), 10'h000}, 1'b0);
                @(posedge pclk);
                slow <= o[0];
                go <= 1'b1;
                @(posedge pclk);
                go <= 1'b0;
                #1;
                for (int i = 1; i <= 5; i++) begin
                    k = 0;
                    while (eq_iter !== 1'b1 && k < 40) begin
                        @(posedge pclk);
                        #1;
                        k++;
                    end
                    if (eq_iter !== 1'b1) stall();
                    @(posedge pclk);
                    #1;
                    chk(preemp_request_q, exp_pe(o, c, i), "request");
                end
            end
        end
        $display("preemphasis test done");
    endtask : t_preemp

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_status();
        t_config();
        t_training();
        t_preemp();
        give_verdict();
    end
endmodule : rxphy_bank_tb
